/* File: acm_top.sv */
// Conversion mode control: register, state decode, conversion clock and sequencer
//
// Overview of operation
// - Reset clears the whole mode control register to zero.
// - The mode register accepts full byte writes and single-bit writes.
// - Run bit clears on a written zero and when a conversion ends.
// - Run bit sets only on a written one while comparator enable is one.
// - Run and enable decode into stopped, standby, converting; run alone illegal.
// - Comparator is powered only while comparator enable is one.
// - Divider field selects periph clock divided by 8, 4, 2 or 1.
// - Ten bit: 23 clocks with 9 sampling, or 17 with 3 sampling.
// - A completed conversion raises the conversion done request.
// - With the clock gate off, mode register and resolution bit hold reset values and ignore writes.
// - Eight bit resolution stops approximation after deciding bit 2.
//
// The implementer's own choice: the Wishbone interface to the registers.
module acm_top (
  input  wire logic                       clk_i,           // Peripheral clock
  input  wire logic                       rst_i,           // Synchronous reset, active high
  input  wire logic                       wb_cyc_i,        // Wishbone cycle
  input  wire logic                       wb_stb_i,        // Wishbone strobe
  input  wire logic                       wb_we_i,         // Wishbone write enable
  input  wire logic [acm_pkg::ADDR_W-1:0] wb_adr_i,        // Wishbone byte address
  input  wire logic [3:0]                 wb_sel_i,        // Wishbone byte selects
  input  wire logic [31:0]                wb_dat_i,        // Wishbone write data
  output logic      [31:0]                wb_dat_o,        // Wishbone read data
  output logic                            wb_ack_o,        // Wishbone acknowledge
  input  wire logic                       comp_result_i,   // Analog comparator output
  output logic                            comp_enable_o,   // Comparator power enable
  output logic                            sample_o,        // Sample-hold in sampling phase
  output logic      [acm_pkg::RES_W-1:0]  trial_o,         // Trial code to comparison voltage
  output logic                            conv_done_irq_o  // Conversion done pulse
);
  import acm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]       mode_q;
  logic [7:0]       mode_d;
  logic             gate_q;
  logic             gate_d;
  logic             res8_q;
  logic             res8_d;
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic [31:0]      rdat_d;
  logic             sync1_q;
  logic             sync2_q;
  logic             sync3_q;
  logic             comp_q;
  logic [4:0]       cnt_q;
  logic [4:0]       cnt_d;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] sar_d;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] trial_q;
  logic             sample_q;
  logic             irq_q;
  logic [5:0]       settle_q;
  acm_state_t       state_w;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Writes land on the edge that samples ack high
  wire req_w      = wb_cyc_i & wb_stb_i;
  wire wr_fire_w  = req_w & wb_we_i & ack_q & wb_sel_i[0];
  wire hit_mode_w = (wb_adr_i == MODE_ADDR);
  wire hit_cfg_w  = (wb_adr_i == CFG_ADDR);
  wire hit_res_w  = (wb_adr_i == RESULT_ADDR);
  wire hit_bit_w  = (wb_adr_i == BITWR_ADDR);
  wire wr_mode_w  = wr_fire_w & hit_mode_w & gate_q;
  wire wr_bit_w   = wr_fire_w & hit_bit_w & gate_q;
  wire wr_cfg_w   = wr_fire_w & hit_cfg_w;
  wire wr_any_w   = wr_mode_w | wr_bit_w;

  wire [2:0] bit_idx_w = wb_dat_i[BITWR_IDX_LSB +: 3];
  wire [7:0] bit_new_w = (mode_q & ~(8'h01 << bit_idx_w)) | (8'(wb_dat_i[BITWR_VAL_BIT]) << bit_idx_w);
  wire [7:0] wbyte_w   = (wr_mode_w ? wb_dat_i[7:0] : bit_new_w) & MODE_WMASK;

  // ---------------------------------------------------------------
  // Mode fields and conversion geometry
  // ---------------------------------------------------------------
  wire       run_w = mode_q[RUN_BIT];
  wire       ce_w  = mode_q[CE_BIT];
  wire       lv_w  = mode_q[LV_BIT];
  wire [1:0] div_w = mode_q[DIV_HI_BIT:DIV_LO_BIT];

  wire [2:0] lim_w = (div_w == 2'h0) ? DIV8_LIM :
                     (div_w == 2'h1) ? DIV4_LIM :
                     (div_w == 2'h2) ? DIV2_LIM : DIV1_LIM;

  wire [4:0] samp_w  = lv_w ? SAMP_SHORT : SAMP_LONG;
  wire [4:0] total_w = (lv_w ? TOTAL_SHORT : TOTAL_LONG) - (res8_q ? RES8_TRIM : 5'h00);
  wire [4:0] nbits_w = res8_q ? NBITS_8 : NBITS_10;

  always_comb
  begin
    unique case ({run_w, ce_w})
      2'b00: state_w = ACM_STOPPED;
      2'b01: state_w = ACM_STANDBY;
      2'b10: state_w = ACM_ILLEGAL;
      2'b11: state_w = ACM_CONVERTING;
    endcase
  end

  // ---------------------------------------------------------------
  // Run bit control
  // ---------------------------------------------------------------
  wire tick_w;
  wire last_w = (cnt_q == total_w - 5'h01);
  wire done_w = (state_w == ACM_CONVERTING) & tick_w & last_w;
  // set needs enable already on and kept
  wire run_set_w = wr_any_w & wbyte_w[RUN_BIT] & ce_w & wbyte_w[CE_BIT];
  // cleared by a written zero or by completion; a set wins
  wire run_next_w = ~gate_q   ? 1'b0 :
                    run_set_w ? 1'b1 :
                    wr_any_w  ? 1'b0 :
                    done_w    ? 1'b0 : run_w;
  wire start_w = run_next_w & (~run_w | done_w);

  // register clears when gated off or reset
  assign mode_d = gate_q ? {run_next_w, (wr_any_w ? wbyte_w[6:0] : mode_q[6:0])} : MODE_RST;

  // Clock gate and resolution select; resolution held clear while gated
  assign gate_d = wr_cfg_w ? wb_dat_i[CFG_GATE_BIT] : gate_q;
  assign res8_d = (gate_q & gate_d) ? (wr_cfg_w ? wb_dat_i[CFG_RES8_BIT] : res8_q) : 1'b0;

  // ---------------------------------------------------------------
  // Conversion clock and sequencer
  // ---------------------------------------------------------------
  // divider restarts with each conversion so the length is exact
  acm_clkdiv u_div (
    .clk_i   (clk_i),
    .clear_i (start_w | (state_w != ACM_CONVERTING)),
    .rst_i   (rst_i),
    .lim_i   (lim_w),
    .tick_o  (tick_w)
  );

  // Decision window follows sampling; one bit decided per conversion clock
  wire [4:0]       k_w      = cnt_q - samp_w;
  wire             decide_w = run_w & (cnt_q >= samp_w) & (k_w < nbits_w);
  wire [3:0]       idx_w    = 4'h9 - k_w[3:0];
  wire [RES_W-1:0] probe_w  = decide_w ? (10'h001 << idx_w) : 10'h000;

  assign cnt_d = start_w ? 5'h00 : (run_w & tick_w & ~last_w) ? cnt_q + 5'h01 : cnt_q;
  // only the decision window writes approximation bits
  assign sar_d = start_w ? 10'h000 :
                 (decide_w & tick_w) ? ((sar_q & ~probe_w) | (comp_q ? probe_w : 10'h000)) : sar_q;

  // Read data mux; unmapped addresses read zero
  assign rdat_d = hit_mode_w ? {24'h00_0000, mode_q} :
                  hit_cfg_w  ? {18'h0_0000, state_w, 3'h0, settle_q == COMP_SETTLE_CYC, 6'h00, res8_q, gate_q} :
                  hit_res_w  ? {22'h00_0000, result_q} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Bus slave: ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req_w & ~ack_q;
      rdat_q <= (req_w & ~ack_q) ? rdat_d : rdat_q;
    end
  end

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= MODE_RST;
      gate_q <= 1'b0;
      res8_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      gate_q <= gate_d;
      res8_q <= res8_d;
    end
  end

  // Comparator sync: a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      comp_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= comp_result_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      comp_q  <= (sync2_q == sync3_q) ? sync3_q : comp_q;
    end
  end

  // Sequencer and analog-facing outputs
  // done pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q    <= 5'h00;
      sar_q    <= 10'h000;
      result_q <= 10'h000;
      trial_q  <= 10'h000;
      sample_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      sar_q    <= sar_d;
      result_q <= done_w ? (res8_q ? {sar_q[9:2], 2'b00} : sar_q) : result_q;
      trial_q  <= sar_q | probe_w;
      sample_q <= run_next_w & (cnt_d < samp_w);
      irq_q    <= done_w;
    end
  end

  // Settling counter; readable so software can pace its start
  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~ce_w)
      settle_q <= 6'h00;
    else if (settle_q != COMP_SETTLE_CYC)
      settle_q <= settle_q + 6'h01;
  end

  // comparator power follows the enable bit
  assign comp_enable_o   = mode_q[CE_BIT];
  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = rdat_q;
  assign sample_o        = sample_q;
  assign trial_o         = trial_q;
  assign conv_done_irq_o = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Cycles since start, for checking the whole conversion length
  logic [7:0] len_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      len_q <= 8'h00;
    else if (start_w)
      len_q <= 8'h01;
    else if (len_q != 8'hff)
      len_q <= len_q + 8'h01;
  end
  wire [7:0] exp_len_w = 8'(total_w) * (8'(lim_w) + 8'h01);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_clear:   assert property ($past(rst_i) |-> mode_q == MODE_RST)
    else $error("mode register not clear after reset");
  a_bit_write:     assert property (wr_bit_w && bit_idx_w == 3'h1 |=> mode_q[LV_BIT] == $past(wb_dat_i[BITWR_VAL_BIT]))
    else $error("single-bit write did not land");
  a_run_enable:    assert property (run_w |-> ce_w)
    else $error("run set with comparator disabled");
  a_set_blocked:   assert property (wr_any_w && !ce_w |=> !run_w)
    else $error("run set while comparator was off");
  a_done_clears:   assert property (done_w && !run_set_w |=> !run_w && conv_done_irq_o ##1 !conv_done_irq_o)
    else $error("run not cleared or done not a pulse");
  a_conv_length:   assert property (done_w |-> len_q == exp_len_w)
    else $error("conversion length wrong");
  a_abort_no_irq:  assert property ($fell(run_w) && !$past(done_w) |-> !conv_done_irq_o)
    else $error("done raised on abort");
  a_gate_hold:     assert property (!gate_q |=> mode_q == MODE_RST && !res8_q)
    else $error("registers not held while gated");
  a_res8_result:   assert property (done_w && res8_q |=> result_q[1:0] == 2'b00)
    else $error("eight bit result has low bits set");
  a_comp_power:    assert property (!comp_enable_o |-> !run_w && !sample_o)
    else $error("conversion active with comparator off");

  c_long_done:  cover property (done_w && !lv_w && !res8_q);
  c_short_done: cover property (done_w && lv_w);
  c_res8_done:  cover property (done_w && res8_q);
  c_abort:      cover property ($fell(run_w) && !$past(done_w));

endmodule

/* File: acm_pkg.sv */
// Package with register map, field layout and timing constants of the conversion mode control block
package acm_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the Wishbone bus)
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 20;
  localparam logic [19:0] MODE_ADDR   = 20'hf_fe30;
  localparam logic [19:0] CFG_ADDR    = 20'hf_fe34;
  localparam logic [19:0] RESULT_ADDR = 20'hf_fe38;
  localparam logic [19:0] BITWR_ADDR  = 20'hf_fe3c;

  // ---------------------------------------------------------------
  // Field layout of conversion_mode_control
  // ---------------------------------------------------------------
  localparam int         RUN_BIT    = 7;
  localparam int         DIV_HI_BIT = 4;
  localparam int         DIV_LO_BIT = 3;
  localparam int         LV_BIT     = 1;
  localparam int         CE_BIT     = 0;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h9b;

  // Configuration register and bit write port fields
  localparam int         CFG_GATE_BIT    = 0;
  localparam int         CFG_RES8_BIT    = 1;
  localparam int         CFG_SETTLED_BIT = 8;
  localparam int         CFG_STATE_LSB   = 12;
  localparam int         BITWR_IDX_LSB   = 0;
  localparam int         BITWR_VAL_BIT   = 3;

  // ---------------------------------------------------------------
  // Conversion timing in conversion clocks
  // ---------------------------------------------------------------
  localparam logic [4:0] SAMP_LONG   = 5'h09;
  localparam logic [4:0] TOTAL_LONG  = 5'h17;
  localparam logic [4:0] SAMP_SHORT  = 5'h03;
  localparam logic [4:0] TOTAL_SHORT = 5'h11;
  localparam logic [4:0] RES8_TRIM   = 5'h02;
  localparam logic [4:0] NBITS_10    = 5'h0a;
  localparam logic [4:0] NBITS_8     = 5'h08;
  localparam int         RES_W       = 10;

  // Divider terminal counts: cycles per conversion clock minus one
  localparam logic [2:0] DIV8_LIM = 3'h7;
  localparam logic [2:0] DIV4_LIM = 3'h3;
  localparam logic [2:0] DIV2_LIM = 3'h1;
  localparam logic [2:0] DIV1_LIM = 3'h0;

  // Comparator settling time, rounded up to whole cycles
  localparam int         COMP_SETTLE_NS  = 100;
  localparam int         CLK_PERIOD_NS   = 4;
  localparam logic [5:0] COMP_SETTLE_CYC = 6'((COMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Operating state decoded from run and comparator enable
  typedef enum logic [1:0] {
    ACM_STOPPED,
    ACM_STANDBY,
    ACM_ILLEGAL,
    ACM_CONVERTING
  } acm_state_t;

endpackage

/* File: acm_clkdiv.sv */
// Conversion clock enable divider for the conversion mode control block
module acm_clkdiv (
  input  wire logic       clk_i,   // Peripheral clock
  input  wire logic       rst_i,   // Synchronous reset, active high
  input  wire logic       clear_i, // Restart the divider
  input  wire logic [2:0] lim_i,   // Terminal count
  output logic            tick_o   // One-cycle conversion clock enable
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // Tick on terminal count; a clear realigns the phase to the start
  assign tick_o = (cnt_q == lim_i) & ~clear_i;
  assign cnt_d  = (clear_i | tick_o) ? 3'h0 : cnt_q + 3'h1;

  // Divider counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d;
  end

endmodule

/* File: acm_analog_model.sv */
// Behavioural sample-hold and comparator facing the conversion sequencer
module acm_analog_model (
  input  wire logic                      clk_i,    // Peripheral clock
  input  wire logic                      enable_i, // Comparator power
  input  wire logic                      sample_i, // Sampling phase
  input  wire logic [acm_pkg::RES_W-1:0] trial_i,  // Trial code
  input  wire logic [acm_pkg::RES_W-1:0] level_i,  // Analog input as a code
  output logic                           result_o  // Comparator decision
);
  timeunit 1ns;
  timeprecision 1ps;
  import acm_pkg::*;

  logic [RES_W-1:0] held_q = '0;
  logic             junk_q = 1'b0;

  // Hold only what was seen while sampling; later pin changes must not leak in
  always_ff @(posedge clk_i)
  begin
    if (sample_i)
      held_q <= level_i;
    junk_q <= ~junk_q;
  end

  // decision only when powered
  // An unpowered comparator gives no answer, so it toggles instead of resting
  assign result_o = enable_i ? (held_q >= trial_i) : junk_q;
endmodule

/* File: acm_top_test.sv */
// Self-checking bench of the conversion mode control block
module acm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import acm_pkg::*;

  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic             clk_i;
  logic             rst_i;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [19:0]      adr;
  logic [31:0]      dat;
  logic [31:0]      rdat;
  logic             ack;
  logic             comp;
  logic             comp_en;
  logic             smp;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] lvl;
  logic             irq;
  int               n_fail = 0;
  int               checked = 0;
  int               cyc_n = 0;
  int               t_ack = 0;
  int               irq_at = 0;
  int               irq_cnt = 0;
  int               smp_cnt = 0;

  acm_top i_dut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_cyc_i       (cyc),
    .wb_stb_i       (stb),
    .wb_we_i        (we),
    .wb_adr_i       (adr),
    .wb_sel_i       (4'hf),
    .wb_dat_i       (dat),
    .wb_dat_o       (rdat),
    .wb_ack_o       (ack),
    .comp_result_i  (comp),
    .comp_enable_o  (comp_en),
    .sample_o       (smp),
    .trial_o        (trial),
    .conv_done_irq_o(irq)
  );

  acm_analog_model i_analog (
    .clk_i   (clk_i),
    .enable_i(comp_en),
    .sample_i(smp),
    .trial_i (trial),
    .level_i (lvl),
    .result_o(comp)
  );

  // 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Edge counter and pulse monitors; NBA keeps all readers on one value
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (irq === 1'b1)
    begin
      irq_at  <= cyc_n;
      irq_cnt <= irq_cnt + 1;
    end
    if (smp === 1'b1)
      smp_cnt <= smp_cnt + 1;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold until ack, then release for at least one cycle
  task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50)
      cmp("ack_timeout", 32'h1, 32'h0);
    q = rdat;
    t_ack = cyc_n;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // unused bits 2, 5, 6 always written zero
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [19:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(nm, e, q & m);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    cmp("irq_rst", 32'h0, {31'h0, irq});
    rdc("mode_rst", MODE_ADDR, {24'h0, MODE_RST}, 32'hffff_ffff);
    wr(MODE_ADDR, 32'h1);
    rdc("mode_gated", MODE_ADDR, 32'h0, 32'hff);
    wr(CFG_ADDR, 32'h1);
    wr(MODE_ADDR, 32'h80);
    rdc("mode_refused", MODE_ADDR, 32'h0, 32'hff);
    // single-bit write of the sample length bit
    wr(BITWR_ADDR, 32'h9);
    rdc("mode_bit", MODE_ADDR, 32'h2, 32'hff);
    rdc("state_stop", CFG_ADDR, 32'h0, 32'h3000);
    rdc("unmapped", 20'hf_fe40, 32'h0, 32'hffff_ffff);
  endtask

  task automatic t_convert(input logic [1:0] dv, input logic lv, input logic r8);
    logic [31:0] md;
    int          tl;
    int          w;
    md = {24'h0, 3'h0, dv, 1'b0, lv, 1'b0};
    tl = (dv == 2'h0) ? 8 : (dv == 2'h1) ? 4 : (dv == 2'h2) ? 2 : 1;
    // stop fully before the next start
    wr(MODE_ADDR, 32'h0);
    wr(CFG_ADDR, {30'h0, r8, 1'b1});
    wr(MODE_ADDR, md);
    wr(MODE_ADDR, md | 32'h1);
    cmp("comp_enable", 32'h1, {31'h0, comp_en});
    rdc("state_standby", CFG_ADDR, 32'h1000, 32'h3000);
    repeat (25) @(posedge clk_i);
    rdc("settled", CFG_ADDR, 32'h100, 32'h100);
    lvl <= lvl + 10'h0d3;
    smp_cnt = 0;
    irq_cnt = 0;
    wr(BITWR_ADDR, 32'hf);
    w = 0;
    while (irq_cnt == 0 && w < 400)
    begin
      @(posedge clk_i);
      w++;
    end
    repeat (3) @(posedge clk_i);
    cmp("duration", (23 - (lv ? 6 : 0) - (r8 ? 2 : 0)) * tl + 1, irq_at - t_ack);
    cmp("sampling", (lv ? 3 : 9) * tl, smp_cnt);
    cmp("done_pulses", 32'h1, irq_cnt);
    rdc("mode_after", MODE_ADDR, md | 32'h1, 32'hff);
    if (dv == 2'h0)
      rdc("result", RESULT_ADDR, {22'h0, lvl & (r8 ? 10'h3fc : 10'h3ff)}, 32'h3ff);
  endtask

  task automatic t_abort;
    wr(MODE_ADDR, 32'h0);
    wr(CFG_ADDR, 32'h1);
    wr(MODE_ADDR, 32'h1);
    repeat (25) @(posedge clk_i);
    irq_cnt = 0;
    wr(MODE_ADDR, 32'h81);
    rdc("state_conv", CFG_ADDR, 32'h3000, 32'h3000);
    wr(MODE_ADDR, 32'h1);
    repeat (250) @(posedge clk_i);
    cmp("abort_pulses", 32'h0, irq_cnt);
    rdc("mode_abort", MODE_ADDR, 32'h1, 32'hff);
    wr(CFG_ADDR, 32'h0);
    rdc("mode_gate_off", MODE_ADDR, 32'h0, 32'hff);
    cmp("comp_enable_off", 32'h0, {31'h0, comp_en});
    wr(MODE_ADDR, 32'h1);
    rdc("mode_locked", MODE_ADDR, 32'h0, 32'hff);
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    dat = '0;
    lvl = 10'h155;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    for (int d = 0; d < 4; d++)
    begin
      t_convert(2'(d), 1'b0, 1'b0);
      t_convert(2'(d), 1'b1, 1'b0);
    end
    t_convert(2'h0, 1'b0, 1'b1);
    t_abort();
    complete_run();
  end

  // Watchdog: the run needs some 1600 cycles, so 20000 means a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
endmodule
